// ---- pkg/reset_strap_params.svh ----
`ifndef RESET_STRAP_PARAMS_SVH
`define RESET_STRAP_PARAMS_SVH
// register byte offsets
`define RS_OFF_CTRL 8'h00
`define RS_OFF_STATUS 8'h04
// control register fields
`define RS_CTRL_SOFT_RESET 0
// status register fields
`define RS_ST_FLOAT 0
`define RS_ST_QSTAT 1
`define RS_ST_NUMERICS 2
`define RS_ST_IN_RESET 3
`define RS_ST_LOCK_BAD 4
// reset values
`define RS_CTRL_RESET 32'h00000000
// clocks from reset release to the coprocessor-wait low sample
`define RS_NUMERICS_DELAY 4
// clocks that controls stay driven inactive before they float
`define RS_INACTIVE_CYCLES 1
// axi response codes
`define RS_RESP_OKAY 2'h0
`define RS_RESP_SLVERR 2'h2
`endif

// ---- pkg/reset_strap_pkg.sv ----
package reset_strap_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ABORT = 2'b01,
        ST_FLOAT = 2'b10
    } rst_phase_e;

    typedef struct packed {
        logic float_test_mode;
        logic qstat_mode;
        logic numerics_mode;
    } mode_s;

    // the seven strap pins, all but the two mid-select pins (not decoded) active low when forced
    typedef struct packed {
        logic read_strobe_qstat_strap;
        logic upper_mem_select;
        logic lower_mem_select;
        logic mid_select0_coproc_req;
        logic mid_select1_coproc_err;
        logic bus_lock;
        logic coproc_wait;
    } strap_s;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_s;
endpackage : reset_strap_pkg

// ---- hw/reset_sync.sv ----
`timescale 1ns/1ns
// two-stage synchroniser for the external reset level and the strap pins
module reset_sync #(
    parameter int WIDTH = 1,
    // level both flops hold while reset is applied
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : reset_sync

// ---- hw/reset_strap_mode_select.sv ----
`timescale 1ns/1ns
`include "reset_strap_params.svh"
module reset_strap_mode_select (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic rst_n,
    // external reset pin
    input wire logic ext_reset_in_n,
    // strap pin inputs
    input wire reset_strap_pkg::strap_s strap_in,
    // strap pin drive from the core when running
    input wire reset_strap_pkg::strap_s core_out,
    input wire logic core_out_en,
    // strap pin outputs
    output reset_strap_pkg::strap_s strap_out,
    output reset_strap_pkg::strap_s strap_oe,
    output reset_strap_pkg::strap_s strap_pullup,
    // core side
    output logic core_reset,
    output logic bus_abort,
    output reset_strap_pkg::mode_s mode,
    // register bus
    input wire reset_strap_pkg::axi_req_s axi_req,
    output reset_strap_pkg::axi_rsp_s axi_rsp
);
    typedef struct packed {
        reset_strap_pkg::rst_phase_e phase;
        logic [2:0] cnt;
        logic cw_high;
        logic cw_pend;
        logic [2:0] cw_cnt;
        reset_strap_pkg::mode_s mode;
        logic float_strap;
        logic qstat_strap;
        logic lock_bad;
        logic soft_reset;
        logic aw_got;
        logic w_got;
        logic aw_ok;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s s_q;
    state_s s_d;
    reset_strap_pkg::strap_s strap_sync;
    logic ext_rst_sync_n;
    logic in_reset;

    // starts as asserted so no run cycle slips out between power-on and the first pin samples
    reset_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(ext_reset_in_n),
        .sync_out(ext_rst_sync_n)
    );

    reset_sync #(.WIDTH(7)) u_strap_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(strap_in),
        .sync_out(strap_sync)
    );

    assign in_reset = !ext_rst_sync_n || s_q.soft_reset;

    function automatic logic is_off(input logic [31:0] a, input logic [7:0] off);
        is_off = (a[7:2] == off[7:2]) && (a[31:8] == 24'h000000);
    endfunction : is_off

    always_comb
    begin
        s_d = s_q;
        // abort sequence: drive inactive, then float
        case (s_q.phase)
            reset_strap_pkg::ST_RUN:
            begin
                if (in_reset)
                begin
                    s_d.phase = reset_strap_pkg::ST_ABORT;
                    s_d.cnt = 3'h0;
                end
            end
            reset_strap_pkg::ST_ABORT:
            begin
                s_d.cnt = s_q.cnt + 3'h1;
                if (s_q.cnt == 3'(`RS_INACTIVE_CYCLES - 1))
                begin
                    s_d.phase = reset_strap_pkg::ST_FLOAT;
                end
            end
            reset_strap_pkg::ST_FLOAT:
            begin
                if (!in_reset)
                begin
                    s_d.phase = reset_strap_pkg::ST_RUN;
                    // latch float-test and qstat modes on release
                    s_d.mode.float_test_mode = s_q.float_strap;
                    s_d.mode.qstat_mode = s_q.qstat_strap;
                    s_d.cw_pend = s_q.cw_high;
                    s_d.cw_cnt = 3'h1;
                end
            end
            default:
            begin
                s_d.phase = reset_strap_pkg::ST_RUN;
            end
        endcase
        if (s_q.phase == reset_strap_pkg::ST_FLOAT && in_reset)
        begin
            // straps sampled continuously while held
            s_d.float_strap = !strap_sync.upper_mem_select && !strap_sync.lower_mem_select;
            s_d.qstat_strap = !strap_sync.read_strobe_qstat_strap;
            s_d.cw_high = strap_sync.coproc_wait;
            s_d.lock_bad = s_q.lock_bad || !strap_sync.bus_lock;
            s_d.mode = '0;
            s_d.cw_pend = 1'b0;
        end
        // coprocessor-wait low four clocks after release
        if (s_q.cw_pend)
        begin
            s_d.cw_cnt = s_q.cw_cnt + 3'h1;
            if (s_q.cw_cnt == 3'(`RS_NUMERICS_DELAY))
            begin
                s_d.cw_pend = 1'b0;
                s_d.mode.numerics_mode = !strap_sync.coproc_wait;
            end
        end
        // axi write
        if (axi_req.awvalid && !s_q.aw_got)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_ok = is_off(axi_req.awaddr, `RS_OFF_CTRL) ||
                is_off(axi_req.awaddr, `RS_OFF_STATUS);
            if (is_off(axi_req.awaddr, `RS_OFF_CTRL))
            begin
                s_d.wdata[31] = 1'b1;
            end
            else
            begin
                s_d.wdata[31] = 1'b0;
            end
        end
        if (axi_req.wvalid && !s_q.w_got)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata[30:0] = {30'h00000000, axi_req.wdata[`RS_CTRL_SOFT_RESET] &&
                axi_req.wstrb[0]};
            s_d.wdata[30] = axi_req.wstrb[0];
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
        begin
            s_d.bvalid = 1'b1;
            s_d.bresp = s_q.aw_ok ? `RS_RESP_OKAY : `RS_RESP_SLVERR;
            if (s_q.wdata[31] && s_q.wdata[30])
            begin
                s_d.soft_reset = s_q.wdata[0];
            end
        end
        if (s_q.bvalid && axi_req.bready)
        begin
            s_d.bvalid = 1'b0;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
        end
        // axi read
        if (axi_req.arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `RS_RESP_OKAY;
            s_d.rdata = 32'h00000000;
            if (is_off(axi_req.araddr, `RS_OFF_CTRL))
            begin
                s_d.rdata[`RS_CTRL_SOFT_RESET] = s_q.soft_reset;
            end
            else if (is_off(axi_req.araddr, `RS_OFF_STATUS))
            begin
                s_d.rdata[`RS_ST_FLOAT] = s_q.mode.float_test_mode;
                s_d.rdata[`RS_ST_QSTAT] = s_q.mode.qstat_mode;
                s_d.rdata[`RS_ST_NUMERICS] = s_q.mode.numerics_mode;
                s_d.rdata[`RS_ST_IN_RESET] = in_reset;
                s_d.rdata[`RS_ST_LOCK_BAD] = s_q.lock_bad;
            end
            else
            begin
                s_d.rresp = `RS_RESP_SLVERR;
            end
        end
        if (s_q.rvalid && axi_req.rready)
        begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.phase <= reset_strap_pkg::ST_FLOAT;
            s_q.soft_reset <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs
    assign core_reset = in_reset || s_q.phase != reset_strap_pkg::ST_RUN;
    assign bus_abort = s_q.phase == reset_strap_pkg::ST_ABORT;
    assign mode = s_q.mode;
    // inactive-high drive during abort, floated with pull-ups after
    assign strap_out = (s_q.phase == reset_strap_pkg::ST_RUN) ? core_out : '1;
    assign strap_oe = (s_q.phase == reset_strap_pkg::ST_ABORT) ? '1 :
        (s_q.phase == reset_strap_pkg::ST_RUN && core_out_en) ? '1 : '0;
    assign strap_pullup = (s_q.phase == reset_strap_pkg::ST_FLOAT) ? '1 : '0;

    assign axi_rsp.awready = !s_q.aw_got;
    assign axi_rsp.wready = !s_q.w_got;
    assign axi_rsp.bvalid = s_q.bvalid;
    assign axi_rsp.bresp = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid = s_q.rvalid;
    assign axi_rsp.rdata = s_q.rdata;
    assign axi_rsp.rresp = s_q.rresp;

    abort_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_q.phase == reset_strap_pkg::ST_RUN && in_reset) |=> bus_abort ##1 !bus_abort);
    float_pullup_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_abort |=> (strap_oe == '0) && (strap_pullup == '1));
    reset_held_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ext_rst_sync_n |-> core_reset);
    sync_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(ext_rst_sync_n) |-> $past(ext_reset_in_n, 2) == 1'b0);
    mode_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_q.phase == reset_strap_pkg::ST_FLOAT && in_reset) |=> mode == '0);
    float_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_q.phase == reset_strap_pkg::ST_FLOAT && !in_reset) |=>
        mode.float_test_mode == $past(s_q.float_strap));
    qstat_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_q.phase == reset_strap_pkg::ST_FLOAT && !in_reset) |=>
        mode.qstat_mode == $past(s_q.qstat_strap));
    numerics_late_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_q.phase == reset_strap_pkg::ST_FLOAT && !in_reset) |=> !mode.numerics_mode [*4]);
    mode_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!core_reset && $past(!core_reset) && !s_q.cw_pend && $past(!s_q.cw_pend)) |->
        $stable(mode));
endmodule : reset_strap_mode_select

// ---- test/board_strap_model.sv ----
`timescale 1ns/1ns
// board reset circuit and strap drivers; resolves each strap pin from all drivers except the forced-low command on bus_lock
module board_strap_model (
    // clock and test commands
    input wire logic core_clk,
    input wire logic hold_rst,
    input wire reset_strap_pkg::strap_s force_low,
    // device pin drive
    input wire reset_strap_pkg::strap_s strap_out,
    input wire reset_strap_pkg::strap_s strap_oe,
    input wire reset_strap_pkg::strap_s strap_pullup,
    // board side
    output logic ext_reset_in_n,
    output reset_strap_pkg::strap_s strap_in
);
    logic toggle_q = 1'b0;
    reset_strap_pkg::strap_s frc;
    always @(posedge core_clk) toggle_q <= ~toggle_q;
    // held low from time zero until the bench lets go
    assign ext_reset_in_n = ~hold_rst;
    always_comb
    begin
        frc = force_low;
        frc.bus_lock = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            // undriven and unpulled pins wander so no stale level is read;
            // the coprocessor holds its wait line high unless told to pull it low
            strap_in[i] = strap_oe[i] ? strap_out[i] : frc[i] ? 1'b0 :
                (strap_pullup[i] || i == 0) ? 1'b1 : toggle_q ^ i[0];
        end
    end
endmodule : board_strap_model

// ---- test/reset_strap_mode_select_tb_top.sv ----
`timescale 1ns/1ns
`include "reset_strap_params.svh"
module reset_strap_mode_select_tb_top;
    logic core_clk, rst_n, hold_rst, core_out_en, ext_reset_in_n, core_reset, bus_abort;
    reset_strap_pkg::strap_s force_low, core_out, strap_in, strap_out, strap_oe, strap_pullup;
    reset_strap_pkg::mode_s mode;
    reset_strap_pkg::axi_req_s req;
    reset_strap_pkg::axi_rsp_s rsp;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] d;
    logic [1:0] r;
    board_strap_model i_board_strap_model (.core_clk(core_clk), .hold_rst(hold_rst),
        .force_low(force_low), .strap_out(strap_out), .strap_oe(strap_oe),
        .strap_pullup(strap_pullup), .ext_reset_in_n(ext_reset_in_n), .strap_in(strap_in));
    reset_strap_mode_select i_reset_strap_mode_select (.core_clk(core_clk), .rst_n(rst_n),
        .ext_reset_in_n(ext_reset_in_n), .strap_in(strap_in), .core_out(core_out),
        .core_out_en(core_out_en), .strap_out(strap_out), .strap_oe(strap_oe),
        .strap_pullup(strap_pullup), .core_reset(core_reset), .bus_abort(bus_abort),
        .mode(mode), .axi_req(req), .axi_rsp(rsp));
    always #5 core_clk = ~core_clk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge core_clk);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!b)
        begin
            @(negedge core_clk);
            aw = aw && (rsp.awready !== 1'b1);
            w = w && (rsp.wready !== 1'b1);
            b = rsp.bvalid === 1'b1;
            rs = rsp.bresp;
            @(posedge core_clk);
            req.awvalid <= aw;
            req.wvalid <= w;
            req.bready <= !b;
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, b;
        ar = 1'b1;
        b = 1'b0;
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        while (!b)
        begin
            @(negedge core_clk);
            ar = ar && (rsp.arready !== 1'b1);
            b = rsp.rvalid === 1'b1;
            v = rsp.rdata;
            rs = rsp.rresp;
            @(posedge core_clk);
            req.arvalid <= ar;
            req.rready <= !b;
        end
    endtask : axi_rd
    // board reset with the given straps forced low, bus_lock excepted, then release
    task automatic boot(input logic [6:0] frc, input logic cw, input logic [2:0] exp_mode);
        @(posedge core_clk);
        hold_rst <= 1'b1;
        force_low <= frc;
        core_out_en <= 1'b0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk(core_reset, 32'h1);
        chk(strap_pullup, 32'h7F);
        chk(strap_oe, 32'h0);
        @(posedge core_clk);
        hold_rst <= 1'b0;
        // wait line drops four clocks after the reset pin rises
        repeat (4) @(posedge core_clk);
        force_low <= cw ? 7'h01 : 7'h00;
        @(negedge core_clk);
        chk(core_reset, 32'h0);
        chk(mode, {29'h0, exp_mode & 3'h6});
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        chk(mode, {29'h0, exp_mode});
        $display("boot %h done", frc);
    endtask : boot
    task automatic t_abort;
        int n;
        n = 0;
        @(posedge core_clk);
        core_out <= 7'h15;
        core_out_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({strap_oe, strap_out}, 32'h3F95);
        @(posedge core_clk);
        hold_rst <= 1'b1;
        @(negedge core_clk);
        chk(core_reset, 32'h0);
        while (bus_abort !== 1'b1 && n < 5)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(n, 32'h3);
        chk({strap_oe, strap_out, core_reset}, 32'h7FFF);
        @(negedge core_clk);
        chk({strap_oe, strap_pullup, bus_abort}, 32'hFE);
        @(negedge core_clk);
        chk(mode, 32'h0);
        $display("abort done");
    endtask : t_abort
    task automatic t_regs;
        axi_rd({24'h000000, `RS_OFF_STATUS}, d, r);
        chk(d[4:0], 32'h1);
        axi_wr({24'h000000, `RS_OFF_CTRL}, 32'h1, r);
        chk(r, `RS_RESP_OKAY);
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk(core_reset, 32'h1);
        axi_rd({24'h000000, `RS_OFF_CTRL}, d, r);
        chk(d, 32'h1);
        axi_rd({24'h000000, `RS_OFF_STATUS}, d, r);
        chk(d[4:0], 32'h8);
        axi_wr({24'h000000, `RS_OFF_CTRL}, 32'h0, r);
        chk(r, `RS_RESP_OKAY);
        axi_wr({24'h000000, `RS_OFF_STATUS}, 32'h1F, r);
        chk(r, `RS_RESP_OKAY);
        axi_rd({24'h000000, `RS_OFF_STATUS}, d, r);
        chk(d[4:0], 32'h0);
        axi_wr(32'h40, 32'h1, r);
        chk(r, `RS_RESP_SLVERR);
        axi_rd(32'h40, d, r);
        chk(d, 32'h0);
        chk(r, `RS_RESP_SLVERR);
        $display("regs done");
    endtask : t_regs
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        hold_rst = 1'b1;
        force_low = 7'h00;
        core_out = 7'h00;
        core_out_en = 1'b0;
        req = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        boot(7'h30, 1'b0, 3'h4);
        t_regs();
        boot(7'h40, 1'b0, 3'h2);
        boot(7'h02, 1'b0, 3'h0);
        boot(7'h00, 1'b1, 3'h1);
        t_abort();
        test_done();
    end
endmodule : reset_strap_mode_select_tb_top
